// ### rtl/uart_receiver_error_irq.sv
// Purpose: receive side of an asynchronous serial port with APB registers
// Assumes: sys_clk 40 MHz; bit time is (baud_divider+1)*16 sys_clk cycles
// Notes:   interrupt output is active low, pulses low for a few cycles
//
// The address map and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
`include "uart_rx_map.svh"
package uart_rx_pkg;
    typedef enum logic [2:0] {
        S_HUNT  = 3'b000,
        S_START = 3'b001,
        S_DATA  = 3'b011,
        S_PAR   = 3'b010,
        S_STOP  = 3'b110,
        S_BRK   = 3'b111
    } rx_state_t;
endpackage : uart_rx_pkg

module uart_receiver_error_irq
    import uart_rx_pkg::*;
#(
    parameter int DEPTH = 2
) (
    input  wire logic        sys_clk,     // 40 MHz clock
    input  wire logic        rstn,        // async reset, active low
    input  wire logic        rx,          // serial line from remote sender
    input  wire logic        txEmpty,     // transmit buffer empty level
    input  wire logic        txIdle,      // transmitter idle level
    input  wire logic        psel,        // apb select
    input  wire logic        penable,     // apb enable
    input  wire logic        pwrite,      // apb direction
    input  wire logic [11:0] paddr,       // apb address
    input  wire logic [31:0] pwdata,      // apb write data
    output logic      [31:0] prdata,      // apb read data
    output logic             pready,      // apb ready
    output logic             pslverr,     // apb error
    output logic             uartIrqN     // interrupt, low pulse
);
    // ****************************************************************
    // reset release and line synchroniser
    // ****************************************************************
    logic [1:0] rstSync;
    logic       rstI;
    logic       rxMeta, rxSync, rxPrev;
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rstSync <= 2'b00;
        end else begin
            rstSync <= {rstSync[0], 1'b1};
        end
    end
    assign rstI = rstSync[1];

    // first stage feeds only the second
    always_ff @(posedge sys_clk or negedge rstI) begin
        if (!rstI) begin
            rxMeta <= 1'b1;
            rxSync <= 1'b1;
            rxPrev <= 1'b1;
        end else begin
            rxMeta <= rx;
            rxSync <= rxMeta;
            rxPrev <= rxSync;
        end
    end

    // ****************************************************************
    // registers and apb slave
    // ****************************************************************
    logic [9:0]  ctrl, next_ctrl;
    logic [7:0]  baudDiv, next_baudDiv;
    logic        armed, next_armed;   // status read seen since last data read
    logic        rdStat, rdData, wrAcc;
    logic [31:0] next_prdata;
    logic [11:0] bufOut;
    logic        avail, ovr, nf, fe, pe, idle;
    logic        pendRd;

    assign wrAcc  = psel && penable && pwrite;
    assign rdStat = psel && penable && !pwrite && paddr == `OFS_STATUS;
    assign rdData = psel && penable && !pwrite && paddr == `OFS_DATA
                    && armed && pready;

    // one wait state on reads lets the buffer word settle
    always_comb begin
        next_ctrl    = ctrl;
        next_baudDiv = baudDiv;
        next_armed   = armed;
        next_prdata  = prdata;
        if (wrAcc && pready) begin
            if (paddr == `OFS_CTRL) begin
                next_ctrl = pwdata[9:0];
            end else if (paddr == `OFS_BAUD) begin
                next_baudDiv = pwdata[7:0];
            end
        end
        // status flags are not writable at all
        if (rdStat) begin
            next_armed = 1'b1;
        end else if (rdData) begin
            next_armed = 1'b0;
        end
        if (psel && !penable && !pwrite) begin
            if (paddr == `OFS_STATUS) begin
                next_prdata = 32'h0;
                next_prdata[`ST_PARITY]  = pe;
                next_prdata[`ST_NOISE]   = nf;
                next_prdata[`ST_FRAMING] = fe;
                next_prdata[`ST_OVERRUN] = ovr;
                next_prdata[`ST_IDLE]    = idle;
                next_prdata[`ST_AVAIL]   = avail;
            end else if (paddr == `OFS_CTRL) begin
                next_prdata = {22'h0, ctrl};
            end else if (paddr == `OFS_BAUD) begin
                next_prdata = {24'h0, baudDiv};
            end else begin
                next_prdata = 32'h0;
            end
        end else if (pendRd) begin
            next_prdata = {23'h0, bufOut[8:0]};
        end
    end

    logic isMapped;
    assign isMapped = paddr == `OFS_STATUS || paddr == `OFS_DATA
                      || paddr == `OFS_CTRL || paddr == `OFS_BAUD;

    always_ff @(posedge sys_clk or negedge rstI) begin
        if (!rstI) begin
            ctrl    <= `CTRL_RESET;
            baudDiv <= `BAUD_RESET;
            armed   <= 1'b0;
            prdata  <= 32'h0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
            pendRd  <= 1'b0;
        end else begin
            ctrl    <= next_ctrl;
            baudDiv <= next_baudDiv;
            armed   <= next_armed;
            prdata  <= next_prdata;
            pendRd  <= psel && !penable && !pwrite && paddr == `OFS_DATA;
            pready  <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && !isMapped;
        end
    end

    // ****************************************************************
    // 16x sample enable from the baud divider
    // ****************************************************************
    logic [7:0] divCnt;
    logic       tick;
    always_ff @(posedge sys_clk or negedge rstI) begin
        if (!rstI) begin
            divCnt <= 8'h00;
            tick   <= 1'b0;
        end else if (divCnt >= baudDiv) begin
            divCnt <= 8'h00;
            tick   <= 1'b1;
        end else begin
            divCnt <= divCnt + 8'h01;
            tick   <= 1'b0;
        end
    end

    // ****************************************************************
    // receive state machine
    // ****************************************************************
    rx_state_t  st, next_st;
    logic [3:0] sub, next_sub;
    logic [3:0] bitN, next_bitN;
    logic [8:0] shReg, next_shReg;
    logic [2:0] votes, next_votes;
    logic       noisy, next_noisy;
    logic       parBit, next_parBit;
    logic       done;
    logic       doneFe, donePe;
    logic       vote;
    logic [3:0] nBits;
    logic       enRx, nine;

    assign enRx  = ctrl[`CT_RECEIVER_ENABLE] && !ctrl[`CT_CLKSTOP];
    assign nine  = ctrl[`CT_NINE];
    assign nBits = nine ? 4'd9 : 4'd8;
    // majority of three samples around mid bit
    assign vote  = (votes[0] & votes[1]) | (votes[1] & votes[2])
                   | (votes[0] & votes[2]);

    always_comb begin
        next_st     = st;
        next_sub    = sub;
        next_bitN   = bitN;
        next_shReg  = shReg;
        next_votes  = votes;
        next_noisy  = noisy;
        next_parBit = parBit;
        done        = 1'b0;
        doneFe      = 1'b0;
        donePe      = 1'b0;
        if (!enRx) begin
            next_st = S_HUNT;
        end else if (tick) begin
            next_sub = sub + 4'd1;
            if (sub == 4'(`VOTE_A) || sub == 4'(`VOTE_B)
                || sub == 4'(`VOTE_C)) begin
                next_votes = {votes[1:0], rxSync};
            end
            case (st)
                S_HUNT: begin
                    next_sub = 4'd0;
                    if (!rxSync) begin
                        next_st    = S_START;
                        next_noisy = 1'b0;
                        next_bitN  = 4'd0;
                    end
                end
                S_START: begin
                    if (sub == 4'(`OVERSAMPLE - 1)) begin
                        if (vote) begin
                            next_st = S_HUNT;              // false start
                        end else begin
                            next_st = S_DATA;
                        end
                    end
                end
                S_DATA: begin
                    if (sub == 4'(`OVERSAMPLE - 1)) begin
                        // lsb arrives first, shift toward bit 0
                        next_shReg = nine ? {vote, shReg[8:1]}
                                          : {1'b0, vote, shReg[7:1]};
                        next_bitN  = bitN + 4'd1;
                        if (bitN + 4'd1 == nBits) begin
                            next_st = ctrl[`CT_PAREN] ? S_PAR : S_STOP;
                        end
                    end
                end
                S_PAR: begin
                    if (sub == 4'(`OVERSAMPLE - 1)) begin
                        next_parBit = vote;
                        next_st     = S_STOP;
                    end
                end
                S_STOP: begin
                    if (sub == 4'(`OVERSAMPLE - 1)) begin
                        done   = 1'b1;
                        doneFe = !vote;
                        donePe = ctrl[`CT_PAREN] &&
                                 ((^shReg) ^ parBit ^ ctrl[`CT_PARODD]);
                        // long low line is a break, not a start
                        next_st = vote ? S_HUNT : S_BRK;
                    end
                end
                default: begin
                    next_sub = 4'd0;
                    if (rxSync) begin
                        next_st = S_HUNT;
                    end
                end
            endcase
            // third sample completes the set; disagreement means noise
            if (st != S_HUNT && st != S_BRK && sub == 4'(`VOTE_C)
                && (votes[1:0] != {2{rxSync}})) begin
                next_noisy = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rstI) begin
        if (!rstI) begin
            st     <= S_HUNT;
            sub    <= 4'd0;
            bitN   <= 4'd0;
            shReg  <= 9'h000;
            votes  <= 3'b111;
            noisy  <= 1'b0;
            parBit <= 1'b0;
        end else begin
            st     <= next_st;
            sub    <= next_sub;
            bitN   <= next_bitN;
            shReg  <= next_shReg;
            votes  <= next_votes;
            noisy  <= next_noisy;
            parBit <= next_parBit;
        end
    end

    // ****************************************************************
    // two-entry buffer and status flags
    // ****************************************************************
    logic [1:0] count, next_count;
    logic       wPtr, next_wPtr, rPtr, next_rPtr;
    logic       push, full;
    logic       next_ovr, next_nf, next_fe, next_pe, next_idle;
    logic [8:0] wordIn;

    assign full = count == 2'(DEPTH);
    assign push = done && !full;
    // a break shifts in zeros and fails its stop bit
    assign wordIn = shReg;

    rx_buffer_mem #(
        .WIDTH (12),
        .DEPTH (DEPTH)
    ) u_mem (
        .sys_clk (sys_clk),
        .we      (push),
        .waddr   (wPtr),
        .wdata   ({donePe, doneFe, noisy, wordIn}),
        .raddr   (rPtr),
        .rdata   (bufOut)
    );

    always_comb begin
        next_count = count;
        next_wPtr  = wPtr;
        next_rPtr  = rPtr;
        next_ovr   = ovr;
        next_nf    = nf;
        next_fe    = fe;
        next_pe    = pe;
        next_idle  = idle;
        if (st == S_HUNT && next_st == S_START) begin
            next_idle = 1'b0;
        end
        if (done) begin
            next_idle = 1'b1;
        end
        // clear by status then data read; a new event below wins
        if (rdData && count != 2'd0) begin
            next_rPtr  = !rPtr;
            next_count = count - 2'd1;
            next_ovr   = 1'b0;
            next_nf    = 1'b0;
        end
        if (push) begin
            next_wPtr  = !wPtr;
            next_count = next_count + 2'd1;
            next_nf    = noisy;
            next_fe    = doneFe;
            next_pe    = donePe;
        end else if (done) begin
            next_ovr   = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge rstI) begin
        if (!rstI) begin
            count <= 2'd0;
            wPtr  <= 1'b0;
            rPtr  <= 1'b0;
            ovr   <= 1'b0;
            nf    <= 1'b0;
            fe    <= 1'b0;
            pe    <= 1'b0;
            idle  <= 1'b1;
        end else begin
            count <= next_count;
            wPtr  <= next_wPtr;
            rPtr  <= next_rPtr;
            ovr   <= next_ovr;
            nf    <= next_nf;
            fe    <= next_fe;
            pe    <= next_pe;
            idle  <= next_idle;
        end
    end
    assign avail = count != 2'd0;

    // ****************************************************************
    // interrupt sources and low pulse
    // ****************************************************************
    logic       rxEv, addrEv, wakeEv, txEv, txEmpPrev, txIdlPrev;
    logic [1:0] pulse, next_pulse;
    logic       trig;
    // receive and overrun share one enable
    assign rxEv   = ctrl[`CT_RIE] && done && !ctrl[`CT_ADDRESS_DETECT_ENABLE];
    assign addrEv = ctrl[`CT_ADDRESS_DETECT_ENABLE] && push
                    && (nine ? wordIn[8] : wordIn[7]);
    assign wakeEv = ctrl[`CT_CLKSTOP] && ctrl[`CT_WAKE]
                    && ctrl[`CT_RIE] && ctrl[`CT_RECEIVER_ENABLE] && rxPrev && !rxSync;
    assign txEv   = (ctrl[`CT_TEIE] && txEmpty && !txEmpPrev)
                    || (ctrl[`CT_TIIE] && txIdle && !txIdlPrev);
    assign trig   = rxEv || addrEv || wakeEv || txEv;

    always_comb begin
        next_pulse = (pulse != 2'd0) ? pulse - 2'd1 : 2'd0;
        if (trig) begin
            next_pulse = 2'(`IRQ_PULSE);
        end
    end

    always_ff @(posedge sys_clk or negedge rstI) begin
        if (!rstI) begin
            pulse     <= 2'd0;
            txEmpPrev <= 1'b0;
            txIdlPrev <= 1'b0;
            uartIrqN  <= 1'b1;
        end else begin
            pulse     <= next_pulse;
            txEmpPrev <= txEmpty;
            txIdlPrev <= txIdle;
            uartIrqN  <= !(next_pulse != 2'd0);
        end
    end
endmodule : uart_receiver_error_irq

// ### shared/uart_rx_map.svh
// Purpose: register map and timing constants of the serial receiver
// Assumes: APB with 32-bit data, one aligned word per register
// Notes:   offsets are byte addresses
// Overview of operation
// - Serial bits enter the shift register least significant bit first.
// - Receive buffer is a two-entry queue; a third byte assembles meanwhile.
// - Third byte done with buffer full sets overrun; buffered bytes kept.
// - With receiver enabled and configured, search the line for a start bit.
// - Data available flag is set while the buffer holds a character.
// - Receive enable requests an interrupt per buffered word and on overrun; here none while address detect is enabled.
// - Break is a framing error: zeros loaded, frame ends after data plus stop.
// - After a break, wait for a high line before the next start bit.
// - Idle flag cleared on start detection, set again only when a stop bit is sampled.
// - Overrun clears only by status access followed by data read.
// - Noise flag rises with data available; data still stored, no own irq.
// - Noise flag clears by status read followed by data read.
// - Framing error set when a stop bit samples low.
// - Parity error set on mismatch, only while parity is enabled.
// - Framing and parity flags clear on any reset.
// - Interrupt is a low pulse from transmit, receive, address and wake sources.
// - Transmit sources own enables; receive and overrun share one enable.
// - Address detect has no flag; its enable raises the interrupt directly.
// - Clock stopped with wake and receive enables: RX falling edge interrupts.
// - Status flags are read-only and not cleared by interrupt vectoring.
// - Line sampled at sixteen per bit, level chosen by majority of three.
// - Nine-bit words put the top bit in the ninth-bit field.
`ifndef UART_RX_MAP_SVH
`define UART_RX_MAP_SVH
// ****************************************************************
// register offsets
// ****************************************************************
`define OFS_STATUS   12'h000
`define OFS_DATA     12'h004
`define OFS_CTRL     12'h008
`define OFS_BAUD     12'h00C
// ****************************************************************
// status bit positions
// ****************************************************************
`define ST_PARITY    0
`define ST_NOISE     1
`define ST_FRAMING   2
`define ST_OVERRUN   3
`define ST_IDLE      4
`define ST_AVAIL     5
// ****************************************************************
// control bit positions
// ****************************************************************
`define CT_RECEIVER_ENABLE      0
`define CT_NINE      1
`define CT_PARODD    2
`define CT_PAREN     3
`define CT_RIE       4
`define CT_ADDRESS_DETECT_ENABLE     5
`define CT_WAKE      6
`define CT_TEIE      7
`define CT_TIIE      8
`define CT_CLKSTOP   9
`define CTRL_RESET   10'h000
`define BAUD_RESET   8'h00
// ****************************************************************
// timing
// ****************************************************************
`define OVERSAMPLE   16
`define VOTE_A       7
`define VOTE_B       8
`define VOTE_C       9
`define IRQ_PULSE    2
`endif

// ### rtl/rx_buffer_mem.sv
// Purpose: two-entry storage of received words with registered read data
// Assumes: writer never writes while full
// Notes:   data and error bits stored together per entry
`timescale 1ns/1ps
module rx_buffer_mem #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 2
) (
    input  wire logic                     sys_clk,   // system clock
    input  wire logic                     we,        // write strobe
    input  wire logic [$clog2(DEPTH)-1:0] waddr,     // write index
    input  wire logic [WIDTH-1:0]         wdata,     // write word
    input  wire logic [$clog2(DEPTH)-1:0] raddr,     // read index
    output logic      [WIDTH-1:0]         rdata      // registered read word
);
    logic [WIDTH-1:0] mem [DEPTH];
    // no reset: contents undefined until written
    always_ff @(posedge sys_clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule : rx_buffer_mem

// ### test/uart_rx_sva.sv
// Purpose: port checker for the serial receiver block
// Assumes: one apb wait state, short low irq pulse
// Notes:   bound to the top module below
`timescale 1ns/1ps
`include "uart_rx_map.svh"
module uart_rx_sva (
    input wire logic        sys_clk,  // system clock
    input wire logic        rstn,     // async reset, active low
    input wire logic        rx,       // serial line
    input wire logic        txEmpty,  // tx buffer empty level
    input wire logic        txIdle,   // tx idle level
    input wire logic        psel,     // apb select
    input wire logic        penable,  // apb enable
    input wire logic        pwrite,   // apb direction
    input wire logic [11:0] paddr,    // apb address
    input wire logic [31:0] pwdata,   // apb write data
    input wire logic [31:0] prdata,   // apb read data
    input wire logic        pready,   // apb ready
    input wire logic        pslverr,  // apb error
    input wire logic        uartIrqN  // interrupt, active low
);
    // ****************************************************************
    // apb timing and interrupt shape
    // ****************************************************************
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    // one wait state
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence answer_s;
        !pready ##1 pready;
    endsequence
    chk_setup_ready: assert property (setup_s |=> answer_s)
        else $error("apb answer not after one wait state");
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    chk_err_map: assert property (pready && paddr[1:0] == 2'b00
        |-> pslverr == (paddr > `OFS_BAUD))
        else $error("pslverr does not match the address map");
    chk_err_zero: assert property (pready && pslverr && !pwrite
        |-> prdata == 32'h0)
        else $error("unmapped read returned nonzero data");
    chk_err_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    chk_no_req: assert property (!psel |=> !pready)
        else $error("pready without a request");
    // prdata holds while idle
    chk_rdata_hold: assert property (!psel |=> $stable(prdata))
        else $error("prdata changed while bus idle");
    chk_irq_width: assert property ($fell(uartIrqN) |=> !uartIrqN)
        else $error("interrupt pulse shorter than two cycles");
endmodule : uart_rx_sva
bind uart_receiver_error_irq uart_rx_sva u_sva (.sys_clk(sys_clk),
    .rstn(rstn), .rx(rx), .txEmpty(txEmpty), .txIdle(txIdle),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .uartIrqN(uartIrqN));

// ### test/uart_line_model.sv
// Purpose: remote asynchronous sender driving the receive line
// Assumes: one bit lasts BIT clock cycles, line idles high
// Notes:   frames and breaks are made on request of the bench
`timescale 1ns/1ps
module uart_line_model #(
    parameter int BIT = 16
) (
    input  wire logic sys_clk, // system clock
    output logic      rx       // serial line into the receiver
);
    initial rx = 1'b1;
    // start, n bits lsb first, stop level, then one idle bit time
    task automatic send(input logic [9:0] w, input int n, input logic stp);
        for (int i = -1; i <= n + 1; i++) begin
            @(posedge sys_clk);
            rx <= (i < 0) ? 1'b0 : (i < n) ? w[i] : (i == n) ? stp : 1'b1;
            repeat (BIT - 1) @(posedge sys_clk);
        end
    endtask : send
    // long low line, then two idle bit times
    task automatic brk(input int bits);
        @(posedge sys_clk);
        rx <= 1'b0;
        repeat (bits * BIT - 1) @(posedge sys_clk);
        rx <= 1'b1;
        repeat (2 * BIT) @(posedge sys_clk);
    endtask : brk
endmodule : uart_line_model

// ### test/test_uart_receiver_error_irq.sv
// Purpose: self-checking bench for the serial receiver block
// Assumes: baud divider 0, so one bit is 16 clock cycles
// Notes:   status is always read before data, which pops the buffer
`timescale 1ns/1ps
`include "uart_rx_map.svh"
module test_uart_receiver_error_irq;
    localparam logic [31:0] RECEIVER_ENABLE = 32'h1 << `CT_RECEIVER_ENABLE;
    localparam logic [31:0] NINE = 32'h1 << `CT_NINE;
    localparam logic [31:0] PODD = 32'h1 << `CT_PARODD;
    localparam logic [31:0] PEN  = 32'h1 << `CT_PAREN;
    localparam logic [31:0] RX_IRQ_ENABLE  = 32'h1 << `CT_RIE;
    localparam logic [31:0] ADEN = 32'h1 << `CT_ADDRESS_DETECT_ENABLE;
    localparam logic [31:0] WAKE = 32'h1 << `CT_WAKE;
    localparam logic [31:0] TEIE = 32'h1 << `CT_TEIE;
    localparam logic [31:0] TIIE = 32'h1 << `CT_TIIE;
    localparam logic [31:0] STOP = 32'h1 << `CT_CLKSTOP;
    logic        sys_clk, rstn, rx, txEmpty, txIdle, psel, penable, pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic        pready, pslverr, uartIrqN, lastErr;
    int          n_fail = 0, checks = 0, irqs = 0, cyc = 0;
    uart_receiver_error_irq dut (.sys_clk(sys_clk), .rstn(rstn), .rx(rx),
        .txEmpty(txEmpty), .txIdle(txIdle), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .uartIrqN(uartIrqN));
    uart_line_model #(.BIT(16)) m (.sys_clk(sys_clk), .rx(rx));
    always #12.5 sys_clk = ~sys_clk;
    always @(negedge uartIrqN) irqs++;
    // hang guard
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 30000) begin
            n_fail++;
            wrap_up;
        end
    end
    // ****************************************************************
    // bus cycles and comparison
    // ****************************************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // request held until pready sampled high
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        q = prdata;
        lastErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        check(q, e);
    endtask : rd
    task automatic st(input logic [5:0] mk, input logic [5:0] e);
        apb(1'b0, `OFS_STATUS, 32'h0);
        check(q & {26'h0, mk}, {26'h0, e});
    endtask : st
    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic t_basic;
        st(6'h3F, 6'h10);
        rd(`OFS_CTRL, 32'h0);
        rd(12'h010, 32'h0);
        check({31'h0, lastErr}, 32'h1);
        apb(1'b1, `OFS_BAUD, 32'h0);
        apb(1'b1, `OFS_CTRL, RECEIVER_ENABLE | RX_IRQ_ENABLE);
        irqs = 0;
        fork
            m.send(10'h0A5, 8, 1'b1);
            begin
                repeat (80) @(posedge sys_clk);
                st(6'h10, 6'h00);
            end
        join
        st(6'h3F, 6'h30);
        check(irqs, 1);
        apb(1'b1, `OFS_STATUS, 32'hFFFFFFFF);
        st(6'h3F, 6'h30);
        rd(`OFS_DATA, 32'hA5);
        st(6'h20, 6'h00);
    endtask : t_basic
    task automatic t_overrun;
        irqs = 0;
        m.send(10'h011, 8, 1'b1);
        m.send(10'h022, 8, 1'b1);
        m.send(10'h033, 8, 1'b1);
        check(irqs, 3);
        st(6'h28, 6'h28);
        rd(`OFS_DATA, 32'h11);
        st(6'h28, 6'h20);
        rd(`OFS_DATA, 32'h22);
        st(6'h20, 6'h00);
    endtask : t_overrun
    task automatic t_break;
        m.send(10'h05A, 8, 1'b0);
        st(6'h24, 6'h24);
        rd(`OFS_DATA, 32'h5A);
        // frame ends while the line is still low
        fork
            m.brk(20);
            begin
                repeat (192) @(posedge sys_clk);
                st(6'h34, 6'h34);
            end
        join
        rd(`OFS_DATA, 32'h0);
        st(6'h20, 6'h00);
    endtask : t_break
    task automatic t_formats;
        logic [9:0] w [4] = '{10'h103, 10'h003, 10'h001, 10'h101};
        logic       od [4] = '{1'b0, 1'b0, 1'b1, 1'b1};
        logic [5:0] pe [4] = '{6'h01, 6'h00, 6'h00, 6'h01};
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, `OFS_CTRL, RECEIVER_ENABLE | PEN | (od[i] ? PODD : 32'h0));
            m.send(w[i], 9, 1'b1);
            st(6'h01, pe[i]);
            rd(`OFS_DATA, {24'h0, w[i][7:0]});
        end
        apb(1'b1, `OFS_CTRL, RECEIVER_ENABLE | NINE);
        m.send(10'h1C3, 9, 1'b1);
        st(6'h20, 6'h20);
        rd(`OFS_DATA, 32'h1C3);
    endtask : t_formats
    task automatic t_irq_sources;
        apb(1'b1, `OFS_CTRL, RECEIVER_ENABLE | RX_IRQ_ENABLE | ADEN);
        irqs = 0;
        m.send(10'h005, 8, 1'b1);
        check(irqs, 0);
        m.send(10'h085, 8, 1'b1);
        check(irqs, 1);
        st(6'h20, 6'h20);
        apb(1'b0, `OFS_DATA, 32'h0);
        st(6'h20, 6'h20);
        apb(1'b0, `OFS_DATA, 32'h0);
        apb(1'b1, `OFS_CTRL, TEIE);
        irqs = 0;
        txEmpty <= 1'b1;
        repeat (6) @(posedge sys_clk);
        txIdle <= 1'b1;
        repeat (6) @(posedge sys_clk);
        check(irqs, 1);
        apb(1'b1, `OFS_CTRL, TIIE);
        txIdle <= 1'b0;
        repeat (6) @(posedge sys_clk);
        txIdle <= 1'b1;
        repeat (6) @(posedge sys_clk);
        check(irqs, 2);
        apb(1'b1, `OFS_CTRL, RECEIVER_ENABLE | WAKE | RX_IRQ_ENABLE | STOP);
        m.send(10'h000, 8, 1'b1);
        check(irqs, 3);
    endtask : t_irq_sources
    task automatic wrap_up;
        if (n_fail == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : wrap_up
    initial begin
        sys_clk = 1'b0; rstn = 1'b0; txEmpty = 1'b0; txIdle = 1'b0;
        psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 12'h000; pwdata = 32'h0;
        repeat (5) @(posedge sys_clk);
        rstn <= 1'b1;
        repeat (4) @(posedge sys_clk);
        t_basic;
        t_overrun;
        t_break;
        t_formats;
        t_irq_sources;
        wrap_up;
    end
endmodule : test_uart_receiver_error_irq
